// [bench/host_sink.sv]
// Purpose: Host side of the answer stream.
// Assumes: One clock; the bench supplies the stall pattern.
// Notes:   A stall is seen one cycle late, as a slow host would show it.
`timescale 1ns/1ps
module host_sink (
  input  wire       clk,
  input  wire       rst_b,
  input  wire [7:0] tx_data,
  input  wire       tx_valid,
  input  wire       stall,
  output reg        tx_ready_ff,
  output reg        got_ff,
  output reg  [7:0] got_byte_ff
);
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) tx_ready_ff <= 1'b0;
    else tx_ready_ff <= !stall;
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      got_ff <= 1'b0;
      got_byte_ff <= 8'h00;
    end else begin
      got_ff <= tx_valid & tx_ready_ff;
      got_byte_ff <= tx_data;
    end
  end
endmodule // host_sink

// [bench/serial_param_frame_protocol_bench.sv]
// Purpose: Self-checking bench of the frame interpreter.
// Assumes: Requests driven at the falling edge; answers taken by host_sink.
// Notes:   A word model mirrors the store, so writes are checked by reads.
`timescale 1ns/1ps
`include "spf_defines.vh"
module serial_param_frame_protocol_bench;
  reg         clk, rst_b, rx_valid, stall;
  reg  [7:0]  rx_data;
  reg  [6:0]  app_idx;
  reg  [1:0]  mode;
  wire        rx_ready_ff, tx_valid, tx_ready, frame_done_ff, frame_nok_ff, got;
  wire [7:0]  tx_data, got_byte;
  wire [15:0] app_word;
  integer     failures, compares, i;
  reg  [31:0] rng;
  reg  [15:0] mem [0:95];
  reg  [7:0]  exp_q[$], req[$], ans[$];
  reg  [7:0]  exp_b;
  reg         exp_n;
  reg         nok_q[$];
  spf_interpreter spf_interpreter_inst (.clk(clk), .rst_b(rst_b), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready_ff(rx_ready_ff), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .app_idx(app_idx), .app_word(app_word),
    .frame_done_ff(frame_done_ff), .frame_nok_ff(frame_nok_ff));
  host_sink host_sink_inst (.clk(clk), .rst_b(rst_b), .tx_data(tx_data), .tx_valid(tx_valid),
    .stall(stall), .tx_ready_ff(tx_ready), .got_ff(got), .got_byte_ff(got_byte));
  function [15:0] xs;
    begin
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      xs = rng[15:0];
    end
  endfunction
  task check(input string name, input [15:0] e, input [15:0] s);
    begin
      compares = compares + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("Error %s expected %h seen %h", name, e, s);
      end
    end
  endtask
  task finish_test;
    begin
      if (failures == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // Holds each byte until the edge that finds ready high takes it.
  task send(input reg bad);
    reg [7:0] ck;
    integer k, n;
    begin
      ck = `SPF_CSUM_SEED;
      for (k = 0; k < req.size(); k++) ck = ck + req[k];
      req.push_back(bad ? ck + 8'h01 : ck);
      for (k = 0; k < req.size(); k++) begin
        @(negedge clk);
        rx_data = req[k];
        rx_valid = 1'b1;
        n = 0;
        while (rx_ready_ff !== 1'b1 && n < 4000) begin
          @(negedge clk);
          n = n + 1;
        end
      end
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data = ~rx_data;
      req.delete();
    end
  endtask
  task xfer(input [7:0] op, input [7:0] adr, input [7:0] cnt, input reg nok, input reg bad);
    integer k;
    reg [15:0] w;
    reg [7:0] ck;
    begin
      req.push_back(op == `SPF_OP_CHECK ? 8'h05 :
                    op == `SPF_OP_WRITE ? 8'h07 + 2 * cnt : 8'h07);
      req.push_back(`SPF_ID_QUESTION);
      req.push_back(`SPF_STATION);
      req.push_back(op);
      ans.push_back(nok ? `SPF_ID_NOK : `SPF_ID_OK);
      ans.push_back(`SPF_STATION);
      ans.push_back(op == `SPF_OP_CHECK && !nok ? `SPF_ANS_CHECK : op);
      if (op != `SPF_OP_CHECK) begin
        req.push_back(adr);
        req.push_back(cnt);
        if (op != `SPF_OP_WRITE && !nok) begin
          ans.push_back(adr);
          ans.push_back(cnt);
        end
      end
      for (k = 0; k < cnt; k++) begin
        w = op == `SPF_OP_RDMIN ? `SPF_PARAM_MIN :
            op == `SPF_OP_RDMAX ? `SPF_PARAM_MAX : mem[adr + k];
        if (op == `SPF_OP_WRITE) begin
          w = xs();
          req.push_back(w[15:8]);
          req.push_back(w[7:0]);
          if (!nok) mem[adr + k] = w;
        end else if (!nok) begin
          ans.push_back(w[15:8]);
          ans.push_back(w[7:0]);
        end
      end
      ck = ans.size() + 2;
      exp_q.push_back(ck);
      for (k = 0; k < ans.size(); k++) begin
        exp_q.push_back(ans[k]);
        ck = ck + ans[k];
      end
      exp_q.push_back(ck);
      nok_q.push_back(nok);
      ans.delete();
      send(bad);
    end
  endtask
  // Waits until the answer is queued: words are committed before it starts.
  task peek(input [6:0] idx);
    begin
      @(negedge clk);
      while (rx_ready_ff !== 1'b1) @(negedge clk);
      app_idx = idx;
      repeat (2) @(negedge clk);
      check("app_word", mem[idx], app_word);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) stall <= mode == 2'd2 || (mode == 2'd1 && xs() > 16'h9FFF);
  always @(negedge clk) begin
    if (got) begin
      exp_b = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
      check("tx_byte", {8'h00, exp_b}, {8'h00, got_byte});
    end
    if (frame_done_ff === 1'b1) begin
      exp_n = nok_q.size() > 0 ? nok_q.pop_front() : 1'bx;
      check("frame_nok", {15'h0, exp_n}, {15'h0, frame_nok_ff});
    end
  end
  initial begin
    #240000;
    failures = failures + 1;
    finish_test;
  end
  initial begin
    failures = 0;
    compares = 0;
    rng = 32'h8;
    rst_b = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    app_idx = 7'h00;
    mode = 2'd0;
    stall = 1'b0;
    for (i = 0; i < 96; i++) mem[i] = `SPF_PARAM_RESET;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    xfer(`SPF_OP_CHECK, 8'h00, 8'h00, 1'b0, 1'b0);
    xfer(`SPF_OP_WRITE, 8'h42, 8'h04, 1'b0, 1'b0);
    peek(7'h43);
    mode = 2'd2;
    fork
      xfer(`SPF_OP_READ, 8'h41, 8'h10, 1'b0, 1'b0);
      begin
        repeat (80) @(negedge clk);
        mode = 2'd1;
      end
    join
    xfer(`SPF_OP_WRITE, 8'h3F, 8'h01, 1'b0, 1'b0);
    peek(7'h3F);
    xfer(`SPF_OP_READ, 8'h3F, 8'h01, 1'b0, 1'b0);
    xfer(`SPF_OP_READ, 8'h3E, 8'h03, 1'b1, 1'b0);
    xfer(`SPF_OP_RDMIN, 8'h00, 8'h02, 1'b0, 1'b0);
    xfer(`SPF_OP_RDMAX, 8'h3F, 8'h01, 1'b0, 1'b0);
    xfer(`SPF_OP_RDMIN, 8'h40, 8'h01, 1'b1, 1'b0);
    xfer(`SPF_OP_READ, 8'h5F, 8'h02, 1'b1, 1'b0);
    xfer(`SPF_OP_READ, 8'h5F, 8'h01, 1'b0, 1'b0);
    xfer(8'h55, 8'h00, 8'h01, 1'b1, 1'b0);
    xfer(`SPF_OP_WRITE, 8'h43, 8'h01, 1'b1, 1'b1);
    xfer(`SPF_OP_READ, 8'h43, 8'h01, 1'b0, 1'b0);
    for (i = 0; i < 6; i++) begin
      xfer(`SPF_OP_WRITE, 8'h50 + (xs() & 8'h07), 8'h01 + (xs() & 8'h07), 1'b0, 1'b0);
      xfer(`SPF_OP_READ, 8'h50, 8'h0F, 1'b0, 1'b0);
    end
    i = 0;
    while (exp_q.size() > 0 && i < 2000) begin
      @(negedge clk);
      i = i + 1;
    end
    check("pending", 16'h0000, exp_q.size());
    check("pending_nok", 16'h0000, nok_q.size());
    finish_test;
  end
endmodule // serial_param_frame_protocol_bench

// [bench/spf_interpreter_sva.sv]
// Purpose: Port checks on the answers of the frame interpreter.
// Assumes: One clock domain; sees only the interpreter ports.
// Notes:   Byte position is rebuilt from the answer length byte.
`timescale 1ns/1ps
`include "spf_defines.vh"
module spf_interpreter_chk (
  input wire        clk,
  input wire        rst_b,
  input wire [7:0]  rx_data,
  input wire        rx_valid,
  input wire        rx_ready_ff,
  input wire [7:0]  tx_data,
  input wire        tx_valid,
  input wire        tx_ready,
  input wire [6:0]  app_idx,
  input wire [15:0] app_word,
  input wire        frame_done_ff,
  input wire        frame_nok_ff
);
  reg  [7:0] cnt_ff;
  reg  [7:0] len_ff;
  reg  [7:0] sum_ff;
  wire       pop  = tx_valid & tx_ready;
  wire       last = (cnt_ff != 8'h00) && (cnt_ff == len_ff - 8'h01);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 8'h00;
      len_ff <= 8'h00;
      sum_ff <= 8'h00;
    end else if (pop) begin
      cnt_ff <= last ? 8'h00 : cnt_ff + 8'h01;
      len_ff <= (cnt_ff == 8'h00) ? tx_data : len_ff;
      sum_ff <= last ? `SPF_CSUM_SEED : sum_ff + tx_data;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_nok_done; frame_nok_ff |-> frame_done_ff; endproperty
  a_nok_done: assert property (p_nok_done) else $error("nok without done");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_hold: assert property (p_hold) else $error("answer byte dropped");
  property p_ready_back; frame_done_ff |-> ##[0:2] rx_ready_ff; endproperty
  a_ready_back: assert property (p_ready_back) else $error("request side stuck");
  property p_len_odd; pop && cnt_ff == 8'h00 |-> tx_data[0] && tx_data >= `SPF_LEN_SHORT;
  endproperty
  a_len_odd: assert property (p_len_odd) else $error("bad answer length");
  property p_id; pop && cnt_ff == 8'h01 |-> tx_data == `SPF_ID_OK || tx_data == `SPF_ID_NOK;
  endproperty
  a_id: assert property (p_id) else $error("bad answer identifier");
  property p_stn; pop && cnt_ff == 8'h02 |-> tx_data == `SPF_STATION; endproperty
  a_stn: assert property (p_stn) else $error("bad station byte");
  property p_ck; pop && last |-> tx_data == sum_ff; endproperty
  a_ck: assert property (p_ck) else $error("bad answer checksum");
  property p_nok_len; pop && cnt_ff == 8'h01 && tx_data == `SPF_ID_NOK |-> len_ff == 8'h05;
  endproperty
  a_nok_len: assert property (p_nok_len) else $error("nok answer not five bytes");
  c_nok: cover property (frame_nok_ff);
  c_ok: cover property (frame_done_ff && !frame_nok_ff);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule // spf_interpreter_chk

bind spf_interpreter spf_interpreter_chk spf_interpreter_chk_inst (.clk(clk), .rst_b(rst_b),
  .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready_ff(rx_ready_ff), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .app_idx(app_idx), .app_word(app_word),
  .frame_done_ff(frame_done_ff), .frame_nok_ff(frame_nok_ff));

// [rtl/spf_interpreter.v]
// Purpose: Slave interpreter for byte-framed parameter question frames.
// Assumes: Request bytes arrive on a same-clock valid/ready stream.
// Notes:   A write is staged and committed only after the whole frame checks.
// How it works
// R1 - First byte is total frame length.
// R2 - Master puts 3Fh in second byte.
// R3 - OK answers use 21h; failures 23h, five bytes.
// R4 - Requests are 5, 7, or 7+2n bytes.
// R5 - Check answer is five bytes, 'd' or 'C'.
// R6 - Read answer echoes address, count, then words.
// R7 - Write carries opcode, address, count, data words.
// R8 - Write answer is five-byte OK frame.
// R9 - Decode check, read, write opcodes; legacy 43h.
// R10 - Address below count selects non-volatile parameter.
// R11 - Higher address selects RAM entry, minus count.
// R12 - Station byte is zero both ways.
// R13 - RAM table starts at data address 40h.
// R14 - Link runs at most 76.6 KBd.
// R15 - Fields follow fixed order, checksum last.
// R16 - Words go most significant byte first.
// R17 - Opcodes 79h/7Ah read parameter minimum/maximum.
// R18 - Checksum is a configurable running byte function.
// R19 - Bad checksum, opcode, length, range give NOK.
`timescale 1ns/1ps
`include "spf_defines.vh"
module spf_interpreter (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [7:0]  rx_data,
  input  wire        rx_valid,
  output reg         rx_ready_ff,
  output wire [7:0]  tx_data,
  output wire        tx_valid,
  input  wire        tx_ready,
  input  wire [6:0]  app_idx,
  output wire [15:0] app_word,
  output reg         frame_done_ff,
  output reg         frame_nok_ff
);
  localparam [2:0] S_LEN    = 3'h0;
  localparam [2:0] S_BODY   = 3'h1;
  localparam [2:0] S_CHECK  = 3'h2;
  localparam [2:0] S_COMMIT = 3'h3;
  localparam [2:0] S_TX     = 3'h4;

  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [7:0]  pos_ff;
  reg  [7:0]  len_ff;
  reg  [7:0]  id_ff;
  reg  [7:0]  stn_ff;
  reg  [7:0]  op_ff;
  reg  [7:0]  adr_ff;
  reg  [7:0]  cnt_ff;
  reg  [7:0]  csum_ff;
  reg  [7:0]  rxsum_ff;
  reg  [15:0] stage_ff [0:63];
  reg         ok_ff;
  reg  [6:0]  wcnt_ff;
  reg  [7:0]  tx_sum_ff;
  reg         req_ok;
  reg  [7:0]  tx_byte;
  reg  [7:0]  tx_len;
  reg  [15:0] tx_word;
  wire        rx_take;
  wire        buf_in_ready;
  wire        buf_in_valid;
  wire [7:0]  data_off;
  wire [6:0]  word_idx;
  wire [8:0]  range_end;
  wire [8:0]  write_len;
  wire [7:0]  tx_off;
  wire [6:0]  tx_widx;
  wire [15:0] store_rd_word;
  wire        is_read;

  function [7:0] csum_step;
    input [7:0] acc;
    input [7:0] b;
    begin
      if (`SPF_CSUM_XOR) begin
        csum_step = acc ^ b; // R18
      end else begin
        csum_step = acc + b; // R18
      end
    end
  endfunction

  // The byte stream is paced by the link; at its rated top speed of
  // 76.6 KBd a byte spans thousands of clocks, so no rate logic is needed.
  assign rx_take   = rx_valid & rx_ready_ff; // R14
  assign data_off  = pos_ff - `SPF_POS_DATA;
  assign word_idx  = data_off[7:1];
  assign range_end = {1'b0, adr_ff} + {1'b0, cnt_ff};
  assign write_len = `SPF_LEN_READ9 + {cnt_ff, 1'b0};
  assign tx_off    = pos_ff - `SPF_POS_DATA;
  assign tx_widx   = tx_off[7:1];
  assign is_read   = (op_ff == `SPF_OP_READ) || (op_ff == `SPF_OP_RDMIN) ||
                     (op_ff == `SPF_OP_RDMAX);

  // Frame acceptance checks.
  always @* begin
    req_ok = (id_ff == `SPF_ID_QUESTION) && (stn_ff == `SPF_STATION) && // R12
             (rxsum_ff == csum_ff) && (len_ff >= `SPF_LEN_SHORT); // R19
    case (op_ff)
      `SPF_OP_CHECK: begin
        req_ok = req_ok && (len_ff == `SPF_LEN_SHORT); // R4
      end
      `SPF_OP_READ: begin
        req_ok = req_ok && (len_ff == `SPF_LEN_READ) && (cnt_ff != 8'h00) && // R4
                 (range_end <= `SPF_RAM_LIMIT) && // R13
                 ((adr_ff >= {1'b0, `SPF_NV_COUNT}) || (range_end <= `SPF_NV_LIMIT));
      end
      `SPF_OP_RDMIN, `SPF_OP_RDMAX: begin
        req_ok = req_ok && (len_ff == `SPF_LEN_READ) && (cnt_ff != 8'h00) && // R17
                 (range_end <= `SPF_NV_LIMIT);
      end
      `SPF_OP_WRITE: begin
        req_ok = req_ok && ({1'b0, len_ff} == write_len) && (cnt_ff != 8'h00) && // R7
                 (range_end <= `SPF_RAM_LIMIT) &&
                 ((adr_ff >= {1'b0, `SPF_NV_COUNT}) || (range_end <= `SPF_NV_LIMIT));
      end
      default: begin
        req_ok = 1'b0; // R9
      end
    endcase
  end

  // Answer length and byte selection.
  always @* begin
    if (!ok_ff || !is_read) begin
      tx_len = `SPF_LEN_SHORT; // R3 R8
    end else begin
      tx_len = `SPF_LEN_READ + {cnt_ff[6:0], 1'b0}; // R6
    end
    case (op_ff)
      `SPF_OP_RDMIN: tx_word = `SPF_PARAM_MIN; // R17
      `SPF_OP_RDMAX: tx_word = `SPF_PARAM_MAX; // R17
      default:       tx_word = store_rd_word;
    endcase
    if (pos_ff == tx_len - 8'h01) begin
      tx_byte = tx_sum_ff; // R15
    end else begin
      case (pos_ff)
        8'h00: tx_byte = tx_len; // R1
        `SPF_POS_ID: tx_byte = ok_ff ? `SPF_ID_OK : `SPF_ID_NOK; // R3
        `SPF_POS_STN: tx_byte = `SPF_STATION; // R12
        `SPF_POS_OP: begin
          if (ok_ff && (op_ff == `SPF_OP_CHECK)) begin
            tx_byte = `SPF_LEGACY_CHECK ? `SPF_ANS_LEGACY : `SPF_ANS_CHECK; // R5
          end else begin
            tx_byte = op_ff; // R3 R8
          end
        end
        `SPF_POS_ADR: tx_byte = adr_ff; // R6
        `SPF_POS_CNT: tx_byte = cnt_ff; // R6
        default: tx_byte = tx_off[0] ? tx_word[7:0] : tx_word[15:8]; // R16
      endcase
    end
  end

  assign buf_in_valid = (state_ff == S_TX);

  // Sequence control.
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_LEN: begin
        if (rx_take) begin
          nxt_state = (rx_data <= 8'h01) ? S_CHECK : S_BODY; // R1
        end
      end
      S_BODY: begin
        if (rx_take && (pos_ff == len_ff - 8'h01)) begin
          nxt_state = S_CHECK;
        end
      end
      S_CHECK: begin
        nxt_state = (req_ok && (op_ff == `SPF_OP_WRITE)) ? S_COMMIT : S_TX;
      end
      S_COMMIT: begin
        if ({1'b0, wcnt_ff} == cnt_ff - 8'h01) begin
          nxt_state = S_TX;
        end
      end
      S_TX: begin
        if (buf_in_ready && (pos_ff == tx_len - 8'h01)) begin
          nxt_state = S_LEN;
        end
      end
      default: begin
        nxt_state = S_LEN;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff      <= S_LEN;
      rx_ready_ff   <= 1'b0;
      pos_ff        <= 8'h00;
      len_ff        <= 8'h00;
      id_ff         <= 8'h00;
      stn_ff        <= 8'h00;
      op_ff         <= 8'h00;
      adr_ff        <= 8'h00;
      cnt_ff        <= 8'h00;
      csum_ff       <= `SPF_CSUM_SEED;
      rxsum_ff      <= 8'h00;
      ok_ff         <= 1'b0;
      wcnt_ff       <= 7'h00;
      tx_sum_ff     <= `SPF_CSUM_SEED;
      frame_done_ff <= 1'b0;
      frame_nok_ff  <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      rx_ready_ff   <= (nxt_state == S_LEN) || (nxt_state == S_BODY);
      frame_done_ff <= 1'b0;
      frame_nok_ff  <= 1'b0;
      case (state_ff)
        S_LEN: begin
          if (rx_take) begin
            len_ff   <= rx_data; // R1
            csum_ff  <= csum_step(`SPF_CSUM_SEED, rx_data); // R18
            rxsum_ff <= ~csum_step(`SPF_CSUM_SEED, rx_data);
            pos_ff   <= 8'h01;
            id_ff    <= 8'h00;
            stn_ff   <= 8'h00;
            op_ff    <= 8'h00;
            adr_ff   <= 8'h00;
            cnt_ff   <= 8'h00;
          end
        end
        S_BODY: begin
          if (rx_take) begin
            pos_ff <= pos_ff + 8'h01;
            if (pos_ff == len_ff - 8'h01) begin
              rxsum_ff <= rx_data; // R15
            end else begin
              csum_ff <= csum_step(csum_ff, rx_data); // R18
              case (pos_ff)
                `SPF_POS_ID:  id_ff  <= rx_data; // R2
                `SPF_POS_STN: stn_ff <= rx_data; // R15
                `SPF_POS_OP:  op_ff  <= rx_data; // R15
                `SPF_POS_ADR: adr_ff <= rx_data; // R15
                `SPF_POS_CNT: cnt_ff <= rx_data; // R15
                default: begin
                end
              endcase
            end
          end
        end
        S_CHECK: begin
          ok_ff     <= req_ok; // R19
          wcnt_ff   <= 7'h00;
          pos_ff    <= 8'h00;
          tx_sum_ff <= `SPF_CSUM_SEED;
        end
        S_COMMIT: begin
          wcnt_ff <= wcnt_ff + 7'h01; // R7
        end
        S_TX: begin
          if (buf_in_ready) begin
            pos_ff    <= pos_ff + 8'h01;
            tx_sum_ff <= csum_step(tx_sum_ff, tx_byte); // R18
            if (pos_ff == tx_len - 8'h01) begin
              frame_done_ff <= 1'b1;
              frame_nok_ff  <= ~ok_ff; // R3
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Write words are staged so a frame that later fails changes nothing.
  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1) begin : g_stage
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          stage_ff[g] <= 16'h0000;
        end else if (rx_take && (state_ff == S_BODY) && (pos_ff >= `SPF_POS_DATA) &&
                     (pos_ff != len_ff - 8'h01) && (data_off[7] == 1'b0) &&
                     (word_idx == g)) begin
          if (data_off[0]) begin
            stage_ff[g][7:0] <= rx_data; // R16
          end else begin
            stage_ff[g][15:8] <= rx_data; // R16
          end
        end
      end
    end
  endgenerate

  spf_param_store u_store (
    .clk         (clk),
    .rst_b       (rst_b),
    .wr_en       (state_ff == S_COMMIT),
    .wr_addr     (adr_ff[6:0] + wcnt_ff), // R10 R11
    .wr_data     (stage_ff[wcnt_ff[5:0]]),
    .rd_addr     (adr_ff[6:0] + tx_widx), // R10 R11
    .rd_word     (store_rd_word),
    .app_idx     (app_idx),
    .app_word_ff (app_word)
  );

  spf_two_entry_buffer u_txbuf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_data   (tx_byte),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );
endmodule // spf_interpreter

// [rtl/spf_param_store.v]
// Purpose: Parameter and RAM table words addressed by frame data address.
// Assumes: Addresses are range-checked by the caller before use.
// Notes:   Application side sees any word through a registered lookup port.
`timescale 1ns/1ps
`include "spf_defines.vh"
module spf_param_store (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        wr_en,
  input  wire [6:0]  wr_addr,
  input  wire [15:0] wr_data,
  input  wire [6:0]  rd_addr,
  output wire [15:0] rd_word,
  input  wire [6:0]  app_idx,
  output reg  [15:0] app_word_ff
);
  reg  [15:0] nv_ff  [0:63];
  reg  [15:0] ram_ff [0:31];

  function in_nv;
    input [6:0] addr;
    begin
      in_nv = (addr < `SPF_NV_COUNT);
    end
  endfunction

  function [15:0] lookup;
    input [6:0] addr;
    reg   [6:0] ram_idx;
    begin
      ram_idx = addr - `SPF_NV_COUNT;
      if (in_nv(addr)) begin
        lookup = nv_ff[addr[5:0]]; // R10
      end else begin
        lookup = ram_ff[ram_idx[4:0]]; // R11
      end
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1) begin : g_nv
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          nv_ff[g] <= `SPF_PARAM_RESET;
        end else if (wr_en && in_nv(wr_addr) && (wr_addr[5:0] == g)) begin
          nv_ff[g] <= wr_data; // R10
        end
      end
    end
    for (g = 0; g < 32; g = g + 1) begin : g_ram
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          ram_ff[g] <= `SPF_PARAM_RESET;
        end else if (wr_en && !in_nv(wr_addr) && (wr_addr - `SPF_NV_COUNT == g)) begin
          ram_ff[g] <= wr_data; // R11
        end
      end
    end
  endgenerate

  assign rd_word = lookup(rd_addr);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      app_word_ff <= `SPF_PARAM_RESET;
    end else begin
      app_word_ff <= lookup(app_idx);
    end
  end
endmodule // spf_param_store

// [rtl/spf_two_entry_buffer.v]
// Purpose: Two-entry byte buffer between the answer builder and the link.
// Assumes: Same clock on both sides; valid and ready handshakes.
// Notes:   Both outputs come from registers, so a stalled receiver loses no byte.
`timescale 1ns/1ps
module spf_two_entry_buffer (
  input  wire       clk,
  input  wire       rst_b,
  input  wire [7:0] in_data,
  input  wire       in_valid,
  output wire       in_ready,
  output wire [7:0] out_data,
  output wire       out_valid,
  input  wire       out_ready
);
  reg  [7:0] head_ff;
  reg  [7:0] spare_ff;
  reg        head_valid_ff;
  reg        spare_valid_ff;
  wire       push;
  wire       pop;

  // The head entry drives the outputs directly; the spare entry catches the
  // byte that arrives in the cycle the receiver stalls.
  assign in_ready  = ~spare_valid_ff;
  assign out_valid = head_valid_ff;
  assign out_data  = head_ff;
  assign push      = in_valid & ~spare_valid_ff;
  assign pop       = head_valid_ff & out_ready;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      head_ff        <= 8'h00;
      spare_ff       <= 8'h00;
      head_valid_ff  <= 1'b0;
      spare_valid_ff <= 1'b0;
    end else begin
      if (pop || !head_valid_ff) begin
        if (spare_valid_ff) begin
          head_ff        <= spare_ff;
          head_valid_ff  <= 1'b1;
          spare_valid_ff <= 1'b0;
        end else begin
          if (push) begin
            head_ff <= in_data;
          end
          head_valid_ff <= push;
        end
      end else if (push) begin
        spare_ff       <= in_data;
        spare_valid_ff <= 1'b1;
      end
    end
  end
endmodule // spf_two_entry_buffer

// [shared/spf_defines.vh]
// Purpose: Constants for the serial parameter frame interpreter.
// Assumes: Byte-wide request and answer streams on one clock.
// Notes:   Included by every design file except the two-entry buffer; definitions only.
`ifndef SPF_DEFINES_VH
`define SPF_DEFINES_VH

// Identifier characters and station byte.
`define SPF_ID_QUESTION  8'h3F
`define SPF_ID_OK        8'h21
`define SPF_ID_NOK       8'h23
`define SPF_STATION      8'h00

// Operation codes.
`define SPF_OP_CHECK     8'h63
`define SPF_OP_READ      8'h77
`define SPF_OP_WRITE     8'h57
`define SPF_OP_RDMIN     8'h79
`define SPF_OP_RDMAX     8'h7A
`define SPF_ANS_CHECK    8'h64
`define SPF_ANS_LEGACY   8'h43
`define SPF_LEGACY_CHECK 1'b0

// Frame layout: byte positions and fixed lengths.
`define SPF_POS_ID       8'h01
`define SPF_POS_STN      8'h02
`define SPF_POS_OP       8'h03
`define SPF_POS_ADR      8'h04
`define SPF_POS_CNT      8'h05
`define SPF_POS_DATA     8'h06
`define SPF_LEN_SHORT    8'h05
`define SPF_LEN_READ     8'h07
`define SPF_LEN_READ9    9'h007

// Address map: parameters below the count, RAM table from it upward.
`define SPF_NV_COUNT     7'h40
`define SPF_NV_LIMIT     9'h040
`define SPF_RAM_COUNT    6'h20
`define SPF_RAM_LIMIT    9'h060
`define SPF_STAGE_WORDS  7'h40

// Checksum: running byte sum modulo 256 from a seed, or XOR when set.
`define SPF_CSUM_SEED    8'h00
`define SPF_CSUM_XOR     1'b0

// Word values.
`define SPF_PARAM_RESET  16'h0000
`define SPF_PARAM_MIN    16'h0000
`define SPF_PARAM_MAX    16'hFFFF

`endif
